/* core/time_sync_aux_pkg.sv */
// constants for the time sync auxiliary pin unit
package time_sync_aux_pkg;
	localparam logic [15:0] off_sync_pin_assignment = 16'h003c;
	localparam logic [15:0] off_rx_stamp_message_filter = 16'h5f50;
	localparam logic [15:0] off_freq_clock0_half_period = 16'hb654;
	localparam logic [15:0] off_freq_clock1_half_period = 16'hb658;
	localparam logic [15:0] off_aux_capture0_nanoseconds = 16'hb65c;
	localparam logic [15:0] off_aux_capture0_seconds = 16'hb660;
	localparam logic [15:0] off_aux_capture1_nanoseconds = 16'hb664;
	localparam logic [15:0] off_aux_capture1_seconds = 16'hb668;
	localparam logic [15:0] off_aux_time_control = 16'hb640;
	localparam int half_period_msb = 29;
	localparam int rx_filter_width = 16;
	localparam int pin_assign_width = 18;
	localparam int cap0_sel_lsb = 0;
	localparam int cap0_en_bit = 2;
	localparam int cap1_sel_lsb = 3;
	localparam int cap1_en_bit = 5;
	localparam int pin_event_lsb = 6;
	localparam int pin_field_stride = 3;
	localparam int ctl_clk0_en_bit = 2;
	localparam int ctl_clk1_en_bit = 5;
	localparam int ctl_cap0_en_bit = 8;
	localparam int ctl_cap0_taken_bit = 9;
	localparam int ctl_cap1_en_bit = 10;
	localparam int ctl_cap1_taken_bit = 11;
	localparam logic [1:0] event_target0 = 2'h0;
	localparam logic [1:0] event_target1 = 2'h1;
	localparam logic [1:0] event_freq0 = 2'h2;
	localparam logic [1:0] event_freq1 = 2'h3;
	localparam int clk_period_ns = 25;
	localparam logic [31:0] reg_reset = 32'h0;
endpackage

/* core/freq_clock_gen.sv */
// one programmable half-period clock generator
`timescale 1ns/1ps
`default_nettype none
module freq_clock_gen
	import time_sync_aux_pkg::*;
#(
	parameter int step_ns = clk_period_ns
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic enable,
	input wire logic [half_period_msb:0] half_period,
	output logic clk_out
);
	logic [half_period_msb+1:0] elapsed;

	// accumulate nanoseconds; toggle each time the programmed half period is crossed
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			elapsed <= '0;
			clk_out <= 1'b0;
		end else if (!enable) begin
			elapsed <= '0;
			clk_out <= 1'b0;
		end else if (elapsed + (half_period_msb+2)'(step_ns) >= {1'b0, half_period}) begin
			// keep remainder so the average period stays exact despite 25 ns steps
			elapsed <= elapsed + (half_period_msb+2)'(step_ns) - {1'b0, half_period};
			clk_out <= ~clk_out;
		end else begin
			elapsed <= elapsed + (half_period_msb+2)'(step_ns);
		end
	end
endmodule
`default_nettype wire

/* core/time_sync_aux_pin_unit.sv */
// auxiliary time sync pin unit: frequency clocks, aux captures, pin routing
`timescale 1ns/1ps
`default_nettype none
module time_sync_aux_pin_unit
	import time_sync_aux_pkg::*;
#(
	parameter int pin_count = 4
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [15:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [31:0] system_time_seconds,
	input wire logic [29:0] system_time_nanoseconds,
	input wire logic target_time0_event,
	input wire logic target_time1_event,
	input wire logic [pin_count-1:0] soft_defined_pin_in,
	output logic [pin_count-1:0] soft_defined_pin_out,
	output logic [pin_count-1:0] soft_defined_pin_oe,
	output logic [7:0] v1_control_match,
	output logic [7:0] v2_message_type_match
);
	logic [pin_assign_width-1:0] sync_pin_assignment;
	logic [rx_filter_width-1:0] rx_stamp_message_filter;
	logic [half_period_msb:0] freq_clock0_half_period;
	logic [half_period_msb:0] freq_clock1_half_period;
	logic freq_clock0_enable, freq_clock1_enable;
	logic capture0_enable, capture1_enable;
	logic [1:0] captured_valid;
	logic [29:0] captured_nanoseconds [2];
	logic [31:0] captured_seconds [2];
	logic [pin_count-1:0] pin_prev;
	logic [1:0] trigger;
	logic [1:0] high_read;
	logic freq_clk0, freq_clk1;
	logic wr, rd;

	assign wr = psel && penable && pwrite;
	assign rd = psel && penable && !pwrite;
	assign pready = 1'b1;
	assign pslverr = 1'b0;
	assign high_read[0] = rd && paddr == off_aux_capture0_seconds;
	assign high_read[1] = rd && paddr == off_aux_capture1_seconds;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync_pin_assignment <= '0;
			rx_stamp_message_filter <= '0;
			freq_clock0_half_period <= '0;
			freq_clock1_half_period <= '0;
			freq_clock0_enable <= 1'b0;
			freq_clock1_enable <= 1'b0;
			capture0_enable <= 1'b0;
			capture1_enable <= 1'b0;
		end else if (wr) begin
			unique case (paddr)
				off_sync_pin_assignment: sync_pin_assignment <= pwdata[pin_assign_width-1:0];
				off_rx_stamp_message_filter: rx_stamp_message_filter <= pwdata[15:0];
				// full 30-bit field kept so 125/250/500 ms half periods still fit
				off_freq_clock0_half_period: freq_clock0_half_period <= pwdata[29:0];
				off_freq_clock1_half_period: freq_clock1_half_period <= pwdata[29:0];
				off_aux_time_control: begin
					freq_clock0_enable <= pwdata[ctl_clk0_en_bit];
					freq_clock1_enable <= pwdata[ctl_clk1_en_bit];
					capture0_enable <= pwdata[ctl_cap0_en_bit];
					capture1_enable <= pwdata[ctl_cap1_en_bit];
				end
				default: ;
			endcase
		end
	end

	assign v1_control_match = rx_stamp_message_filter[7:0];
	assign v2_message_type_match = rx_stamp_message_filter[15:8];

	freq_clock_gen gen0 (
		.pclk(pclk),
		.presetn(presetn),
		.enable(freq_clock0_enable),
		.half_period(freq_clock0_half_period),
		.clk_out(freq_clk0)
	);

	freq_clock_gen gen1 (
		.pclk(pclk),
		.presetn(presetn),
		.enable(freq_clock1_enable),
		.half_period(freq_clock1_half_period),
		.clk_out(freq_clk1)
	);

	// pin inputs are synchronous; one stage remembers the previous level for edge detect
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_prev <= '0;
		end else begin
			pin_prev <= soft_defined_pin_in;
		end
	end

	always_comb begin
		logic [1:0] s0, s1;
		s0 = sync_pin_assignment[cap0_sel_lsb +: 2];
		s1 = sync_pin_assignment[cap1_sel_lsb +: 2];
		trigger[0] = capture0_enable && sync_pin_assignment[cap0_en_bit]
			&& (soft_defined_pin_in[s0] != pin_prev[s0]);
		trigger[1] = capture1_enable && sync_pin_assignment[cap1_en_bit]
			&& (soft_defined_pin_in[s1] != pin_prev[s1]);
	end

	genvar c;
	generate
		for (c = 0; c < 2; c++) begin : g_cap
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					captured_valid[c] <= 1'b0;
					captured_nanoseconds[c] <= '0;
					captured_seconds[c] <= '0;
				end else if (trigger[c] && (!captured_valid[c] || high_read[c])) begin
					// a trigger in the releasing read's cycle is kept, not lost
					captured_valid[c] <= 1'b1;
					captured_nanoseconds[c] <= system_time_nanoseconds;
					captured_seconds[c] <= system_time_seconds;
				end else if (high_read[c]) begin
					captured_valid[c] <= 1'b0;
				end
			end
		end
	endgenerate

	genvar p;
	generate
		for (p = 0; p < pin_count; p++) begin : g_pin
			logic [1:0] sel;
			logic en;
			assign sel = sync_pin_assignment[pin_event_lsb + p*pin_field_stride +: 2];
			assign en = sync_pin_assignment[pin_event_lsb + p*pin_field_stride + 2];
			assign soft_defined_pin_oe[p] = en;
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					soft_defined_pin_out[p] <= 1'b0;
				end else if (!en) begin
					soft_defined_pin_out[p] <= 1'b0;
				end else begin
					unique case (sel)
						event_target0: soft_defined_pin_out[p] <= target_time0_event;
						event_target1: soft_defined_pin_out[p] <= target_time1_event;
						event_freq0: soft_defined_pin_out[p] <= freq_clk0;
						event_freq1: soft_defined_pin_out[p] <= freq_clk1;
					endcase
				end
			end
		end
	endgenerate

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= reg_reset;
		end else if (psel && !penable && !pwrite) begin
			unique case (paddr)
				off_sync_pin_assignment: prdata <= {14'h0, sync_pin_assignment};
				off_rx_stamp_message_filter: prdata <= {16'h0, rx_stamp_message_filter};
				off_freq_clock0_half_period: prdata <= {2'h0, freq_clock0_half_period};
				off_freq_clock1_half_period: prdata <= {2'h0, freq_clock1_half_period};
				off_aux_capture0_nanoseconds: prdata <= {2'h0, captured_nanoseconds[0]};
				off_aux_capture0_seconds: prdata <= captured_seconds[0];
				off_aux_capture1_nanoseconds: prdata <= {2'h0, captured_nanoseconds[1]};
				off_aux_capture1_seconds: prdata <= captured_seconds[1];
				off_aux_time_control: begin
					prdata <= '0;
					prdata[ctl_clk0_en_bit] <= freq_clock0_enable;
					prdata[ctl_clk1_en_bit] <= freq_clock1_enable;
					prdata[ctl_cap0_en_bit] <= capture0_enable;
					prdata[ctl_cap0_taken_bit] <= captured_valid[0];
					prdata[ctl_cap1_en_bit] <= capture1_enable;
					prdata[ctl_cap1_taken_bit] <= captured_valid[1];
				end
				default: prdata <= '0;
			endcase
		end
	end
endmodule
`default_nettype wire

/* dv/pin_partner.sv */
// external circuitry on the soft defined pins
`timescale 1ns/1ps
`default_nettype none
module pin_partner #(
	parameter int pin_count = 4
) (
	input wire logic [pin_count-1:0] drive_level,
	input wire logic [pin_count-1:0] pin_out,
	input wire logic [pin_count-1:0] pin_oe,
	output logic [pin_count-1:0] pin_level
);
	// trigger pins stay inputs: far side drives only pins the unit leaves alone
	assign pin_level = (pin_oe & pin_out) | (~pin_oe & drive_level);
endmodule
`default_nettype wire

/* dv/time_sync_aux_pin_unit_checker.sv */
// port assertions for the time sync aux pin unit
`timescale 1ns/1ps
`default_nettype none
module time_sync_aux_pin_unit_checker
	import time_sync_aux_pkg::*;
#(
	parameter int pin_count = 4
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [15:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic target_time0_event,
	input wire logic target_time1_event,
	input wire logic [pin_count-1:0] soft_defined_pin_out,
	input wire logic [pin_count-1:0] soft_defined_pin_oe,
	input wire logic [7:0] v1_control_match,
	input wire logic [7:0] v2_message_type_match
);
	logic [17:0] asg;
	wire logic wr = psel && penable && pwrite;
	wire logic rd = psel && penable && !pwrite;
	// shadow of the pin assignment word, loaded at the same edge as the register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) asg <= 18'h0;
		else if (wr && paddr == off_sync_pin_assignment) asg <= pwdata[17:0];
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_v1_field: assert property (wr && paddr == off_rx_stamp_message_filter |=>
		{24'h0, v1_control_match} == ($past(pwdata) & 32'hff)) else $error("v1 field bad");
	a_v2_field: assert property (wr && paddr == off_rx_stamp_message_filter |=>
		{16'h0, v2_message_type_match, 8'h0} == ($past(pwdata) & 32'hff00)) else $error("v2 bad");
	a_rx_reserved: assert property (rd && paddr == off_rx_stamp_message_filter |->
		prdata[31:16] == 16'h0) else $error("rx filter upper bits set");
	a_low_top_zero: assert property (rd && (paddr == off_aux_capture0_nanoseconds ||
		paddr == off_aux_capture1_nanoseconds) |-> prdata[31:30] == 2'h0) else $error("ns top");
	a_oe_fields: assert property (soft_defined_pin_oe[3:0] ==
		{asg[17], asg[14], asg[11], asg[8]}) else $error("pin enable mismatch");
	a_free_pin: assert property (!asg[11] |-> !soft_defined_pin_oe[1])
		else $error("unassigned pin driven");
	a_target0_route: assert property ($stable(asg) && asg[8] && asg[7:6] == event_target0
		|-> soft_defined_pin_out[0] == $past(target_time0_event)) else $error("target0 route");
	a_target1_route: assert property ($stable(asg) && asg[11] && asg[10:9] == event_target1
		|-> soft_defined_pin_out[1] == $past(target_time1_event)) else $error("target1 route");
endmodule
`default_nettype wire
bind time_sync_aux_pin_unit time_sync_aux_pin_unit_checker #(.pin_count(pin_count)) chk_i (
	.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .target_time0_event,
	.target_time1_event, .soft_defined_pin_out, .soft_defined_pin_oe, .v1_control_match,
	.v2_message_type_match);

/* dv/testbench.sv */
// self-checking bench for the time sync aux pin unit
`timescale 1ns/1ps
`default_nettype none
module testbench
	import time_sync_aux_pkg::*;
;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic pready, pslverr, tt0 = 0, tt1 = 0;
	logic [15:0] paddr = 16'h0;
	logic [31:0] pwdata = 32'h0, prdata, sys_s = 32'h0, r;
	logic [29:0] sys_ns = 30'h0;
	logic [3:0] ext = 4'h0, pin_in, pin_out, pin_oe;
	logic [7:0] v1, v2;
	int errors = 0, n_tests = 0, n;
	always #12.5 pclk = ~pclk;
	time_sync_aux_pin_unit dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .system_time_seconds(sys_s), .system_time_nanoseconds(sys_ns),
		.target_time0_event(tt0), .target_time1_event(tt1), .soft_defined_pin_in(pin_in),
		.soft_defined_pin_out(pin_out), .soft_defined_pin_oe(pin_oe), .v1_control_match(v1),
		.v2_message_type_match(v2));
	pin_partner far (.drive_level(ext), .pin_out, .pin_oe, .pin_level(pin_in));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// idle edge first, so back-to-back calls never assign psel twice in one step
	task automatic xfer(input logic w, input logic [15:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		do @(posedge pclk); while (pready !== 1'b1);
		r = prdata;
		psel <= 0;
		penable <= 0;
	endtask
	task automatic rc(input logic [15:0] a, input logic [31:0] exp);
		xfer(0, a, 32'h0);
		chk(r, exp);
	endtask
	task automatic t_reset();
		for (int a = 32'hb640; a <= 32'hb668; a += 4) rc(a[15:0], 32'h0);
		rc(off_sync_pin_assignment, 32'h0);
		rc(off_rx_stamp_message_filter, 32'h0);
		$display("reset values done");
	endtask
	task automatic t_regs();
		xfer(1, off_rx_stamp_message_filter, 32'hffff_a55a);
		rc(off_rx_stamp_message_filter, 32'h0000_a55a);
		chk({16'h0, v2, v1}, 32'h0000_a55a);
		xfer(1, off_freq_clock0_half_period, 32'hffff_ffff);
		xfer(1, off_freq_clock1_half_period, 32'h1234_5678);
		rc(off_freq_clock0_half_period, 32'h3fff_ffff);
		rc(off_freq_clock1_half_period, 32'h1234_5678);
		xfer(1, off_aux_capture0_seconds, 32'hffff_ffff);
		xfer(1, off_aux_capture1_nanoseconds, 32'hffff_ffff);
		rc(off_aux_capture0_seconds, 32'h0);
		rc(off_aux_capture1_nanoseconds, 32'h0);
		xfer(1, off_sync_pin_assignment, 32'hffff_ffff);
		rc(off_sync_pin_assignment, 32'h0003_ffff);
		xfer(1, off_sync_pin_assignment, 32'h0);
		$display("register access done");
	endtask
	task automatic t_capture();
		sys_s <= 32'h0000_1111;
		sys_ns <= 30'h0222_2222;
		xfer(1, off_aux_time_control, 32'h0000_0500);
		xfer(1, off_sync_pin_assignment, 32'h0000_003e);
		ext <= 4'h4;
		rc(off_aux_time_control, 32'h0000_0700);
		sys_s <= 32'h0000_3333;
		ext <= 4'h0;
		rc(off_aux_capture0_nanoseconds, 32'h0222_2222);
		rc(off_aux_capture0_seconds, 32'h0000_1111);
		rc(off_aux_time_control, 32'h0000_0500);
		ext <= 4'h8;
		rc(off_aux_capture1_seconds, 32'h0000_3333);
		ext <= 4'hc;
		rc(off_aux_capture0_seconds, 32'h0000_3333);
		xfer(1, off_sync_pin_assignment, 32'h0000_0038);
		ext <= 4'h8;
		rc(off_aux_time_control, 32'h0000_0500);
		$display("capture done");
	endtask
	task automatic t_freq();
		xfer(1, off_freq_clock0_half_period, 32'd100);
		xfer(1, off_sync_pin_assignment, 32'h0000_0180);
		repeat (20) @(posedge pclk);
		chk({31'h0, pin_out[0]}, 32'h0);
		xfer(1, off_aux_time_control, 32'h0000_0004);
		n = 0;
		while (pin_out[0] !== 1'b1 && n < 50) begin
			@(posedge pclk);
			n++;
		end
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pin_out[0] === 1'b1 && n < 50);
		chk(n, 32'd4);
		xfer(1, off_aux_time_control, 32'h0);
		$display("frequency clock done");
	endtask
	task automatic t_route();
		xfer(1, off_sync_pin_assignment, 32'h0003_eb00);
		tt0 <= 1;
		repeat (3) @(posedge pclk);
		chk({24'h0, pin_oe, pin_out}, 32'h0000_00f1);
		tt0 <= 0;
		tt1 <= 1;
		repeat (3) @(posedge pclk);
		chk({28'h0, pin_out}, 32'h2);
		$display("pin routing done");
	endtask
	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	// about 170 cycles are needed; the margin covers a stalled pready
	initial begin
		repeat (5000) @(posedge pclk);
		errors++;
		end_sim();
	end
	initial begin
		repeat (12) @(posedge pclk);
		presetn <= 1;
		t_reset();
		t_regs();
		t_capture();
		t_freq();
		t_route();
		end_sim();
	end
endmodule
`default_nettype wire
